// ### include/vpc_pkg.sv
// Purpose: Shared constants and types for the video port control bank
// Assumes: 32-bit classic Wishbone register access, byte addressed
// Notes:   All registers reset to zero
package vpc_pkg;

    // Bus widths
    localparam int unsigned WB_AW = 8;
    localparam int unsigned WB_DW = 32;

    // Register byte offsets
    localparam logic [WB_AW-1:0] ADDR_CAP0 = 8'h00;
    localparam logic [WB_AW-1:0] ADDR_CAP1 = 8'h04;
    localparam logic [WB_AW-1:0] ADDR_DISP = 8'h08;
    localparam logic [WB_AW-1:0] ADDR_STAT = 8'h0C;

    // Reset values
    localparam logic [31:0] CAP_RESET  = 32'h0000_0000;
    localparam logic [31:0] DISP_RESET = 32'h0000_0000;

    // Writable bits of each register
    localparam logic [31:0] CAP0_WR_MASK = 32'h0000_000F;
    localparam logic [31:0] CAP1_WR_MASK = 32'h0000_001F;
    localparam logic [31:0] DISP_WR_MASK = 32'h8000_7FDB;

    // Field positions
    localparam int unsigned CAP_MUX_BIT  = 3;
    localparam int unsigned MODE_RAW_BIT = 1;

    // Capture channel control word
    typedef struct packed {
        logic [25:0] rsvd;
        logic        field_id;
        logic        addr_format;
        logic        luma_chroma_mux;
        logic [1:0]  data_mode;
        logic        enable;
    } vpc_cap_ctrl_t;

    // Display channel control word
    typedef struct packed {
        logic        clock_edge_select;
        logic [15:0] rsvd_hi;
        logic        blank_clip_enable;
        logic        active_clip_enable;
        logic        field_frame;
        logic        scan_format;
        logic        pixel_enable;
        logic        vert_anc_enable;
        logic        horiz_anc_enable;
        logic [1:0]  frame_irq_select;
        logic        field_id;
        logic        addr_format;
        logic        luma_chroma_mux;
        logic        rsvd_lo;
        logic        clock_enable;
        logic        enable;
    } vpc_disp_ctrl_t;

    // Capture status word
    typedef struct packed {
        logic [26:0] rsvd;
        logic        mode_mismatch;
        logic        raw_mode;
        logic        cap1_active;
        logic        cap0_active;
        logic        started;
    } vpc_status_t;

endpackage : vpc_pkg

// ### hw/vpc_fid_latch.sv
// Purpose: Holds a channel's field identification between frame pulses
// Assumes: frame_pulse_i is a one-cycle pulse on clk_i
// Notes:   Value shown is 0 for top field, 1 for bottom field
`timescale 1ns/1ps
module vpc_fid_latch (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic frame_pulse_i,
    input  wire logic field_i,
    output logic      fid_o
);
    import vpc_pkg::*;

    // Capture field only on the frame pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fid_o <= 1'b0;
        end else if (frame_pulse_i) begin
            fid_o <= field_i;
        end
    end

    property p_fid_hold;
        @(posedge clk_i) disable iff (rst_i)
        !frame_pulse_i |=> $stable(fid_o);
    endproperty
    a_fid_hold: assert property (p_fid_hold)
        else $error("field id changed without frame pulse");

    property p_fid_take;
        @(posedge clk_i) disable iff (rst_i)
        frame_pulse_i |=> fid_o == $past(field_i);
    endproperty
    a_fid_take: assert property (p_fid_take)
        else $error("field id not taken on frame pulse");

endmodule : vpc_fid_latch

// ### hw/vpc_regs.sv
// Purpose: Capture and display channel control registers of a video port
// Assumes: Classic Wishbone slave, single clock, synchronous reset
// Notes:   Capture run state is derived here and driven to the datapath
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
module vpc_regs (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone slave
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [vpc_pkg::WB_AW-1:0] adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [vpc_pkg::WB_DW-1:0] dat_i,
    output logic [vpc_pkg::WB_DW-1:0]  dat_o,
    output logic                       ack_o,
    // Field tracking from the datapath
    input  wire logic                  cap1_frame_pulse_i,
    input  wire logic                  cap1_field_i,
    input  wire logic                  disp_frame_pulse_i,
    input  wire logic                  disp_field_i,
    // Controls to the datapath
    output vpc_pkg::vpc_cap_ctrl_t     cap0_ctrl_o,
    output vpc_pkg::vpc_cap_ctrl_t     cap1_ctrl_o,
    output vpc_pkg::vpc_disp_ctrl_t    disp_ctrl_o,
    output vpc_pkg::vpc_status_t       status_o,
    output logic                       cap1_luma_subpic_o,
    output logic                       cap1_anc_subpic_o,
    output logic                       disp_clock_edge_select_o,
    output logic                       cap1_field_id_o,
    output logic                       disp_field_id_o
);
    import vpc_pkg::*;

    vpc_cap_ctrl_t  cap0_q;
    vpc_cap_ctrl_t  cap1_q;
    vpc_disp_ctrl_t disp_q;
    vpc_status_t    stat_d;
    logic [31:0]    bmask;
    logic [31:0]    rdata;
    logic           wr_en;
    logic           cap1_mux0_wr;
    logic [1:0]     frame_pulse;
    logic [1:0]     field_in;
    logic [1:0]     fid;

    // Byte lanes to bit mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bmask[i*8 +: 8] = {8{sel_i[i]}};
        end
    end

    // Writes commit on the edge at which the master sees ack
    assign wr_en = cyc_i && stb_i && we_i && ack_o;
    assign cap1_mux0_wr = wr_en && (adr_i == ADDR_CAP1) && sel_i[0]
                          && !dat_i[CAP_MUX_BIT];

    // Bus acknowledge, one wait state, dropped after one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    // First capture channel control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap0_q <= vpc_cap_ctrl_t'(CAP_RESET);
        end else begin
            if (wr_en && adr_i == ADDR_CAP0) begin
                cap0_q <= vpc_cap_ctrl_t'((cap0_q & ~(bmask & CAP0_WR_MASK))
                          | (dat_i & bmask & CAP0_WR_MASK));
            end
            if (cap1_mux0_wr || (!cap1_q.luma_chroma_mux && wr_en
                && adr_i == ADDR_CAP0)) begin
                cap0_q.luma_chroma_mux <= 1'b1;
            end
        end
    end

    // Second capture channel control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap1_q <= vpc_cap_ctrl_t'(CAP_RESET);
        end else if (wr_en && adr_i == ADDR_CAP1) begin
            cap1_q <= vpc_cap_ctrl_t'((cap1_q & ~(bmask & CAP1_WR_MASK))
                      | (dat_i & bmask & CAP1_WR_MASK));
        end
    end

    // Display channel control, read-only bits never written
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            disp_q <= vpc_disp_ctrl_t'(DISP_RESET);
        end else if (wr_en && adr_i == ADDR_DISP) begin
            disp_q <= vpc_disp_ctrl_t'((disp_q & ~(bmask & DISP_WR_MASK))
                      | (dat_i & bmask & DISP_WR_MASK));
        end
    end

    // Field id latches for capture channel 1 and display
    assign frame_pulse = {disp_frame_pulse_i, cap1_frame_pulse_i};
    assign field_in    = {disp_field_i, cap1_field_i};

    generate
        for (genvar g = 0; g < 2; g++) begin : g_fid
            vpc_fid_latch u_fid (
                .clk_i         (clk_i),
                .rst_i         (rst_i),
                .frame_pulse_i (frame_pulse[g]),
                .field_i       (field_in[g]),
                .fid_o         (fid[g])
            );
        end
    endgenerate

    // Capture run state from enables, mux and data mode
    always_comb begin
        logic raw;
        logic muxed;
        logic both;
        raw   = cap0_q.data_mode[MODE_RAW_BIT];
        muxed = cap0_q.luma_chroma_mux && cap1_q.luma_chroma_mux;
        both  = cap0_q.enable && cap1_q.enable;
        stat_d = '0;
        if (!raw && muxed) begin
            stat_d.cap0_active = cap0_q.enable;
            stat_d.cap1_active = cap1_q.enable;
        end else begin
            stat_d.cap0_active = both;
            stat_d.cap1_active = both;
        end
        stat_d.started       = stat_d.cap0_active || stat_d.cap1_active;
        stat_d.raw_mode      = raw;
        stat_d.mode_mismatch = cap0_q.data_mode != cap1_q.data_mode;
    end

    // Read data select, reserved bits read zero
    always_comb begin
        rdata = '0;
        unique case (adr_i)
            ADDR_CAP0: rdata = 32'(cap0_q) & CAP0_WR_MASK;
            ADDR_CAP1: begin
                rdata = 32'(cap1_q) & CAP1_WR_MASK;
                rdata[5] = fid[0];
            end
            ADDR_DISP: begin
                rdata = 32'(disp_q) & DISP_WR_MASK;
                rdata[5] = fid[1];
            end
            ADDR_STAT: rdata = 32'(stat_d);
            default:   rdata = '0;
        endcase
    end

    // Registered read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else if (cyc_i && stb_i && !we_i && !ack_o) begin
            dat_o <= rdata;
        end
    end

    // Registered controls to the datapath
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap0_ctrl_o        <= vpc_cap_ctrl_t'(CAP_RESET);
            cap1_ctrl_o        <= vpc_cap_ctrl_t'(CAP_RESET);
            disp_ctrl_o        <= vpc_disp_ctrl_t'(DISP_RESET);
            status_o           <= '0;
            cap1_luma_subpic_o <= 1'b0;
            cap1_anc_subpic_o  <= 1'b0;
        end else begin
            cap0_ctrl_o        <= cap0_q;
            cap1_ctrl_o        <= cap1_q;
            disp_ctrl_o        <= disp_q;
            status_o           <= stat_d;
            cap1_luma_subpic_o <= cap1_q.addr_format
                                  && !cap1_q.data_mode[MODE_RAW_BIT];
            cap1_anc_subpic_o  <= 1'b0;
        end
    end

    // Edge select and field ids out
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            disp_clock_edge_select_o <= 1'b0;
            cap1_field_id_o          <= 1'b0;
            disp_field_id_o          <= 1'b0;
        end else begin
            disp_clock_edge_select_o <= disp_q.clock_edge_select;
            cap1_field_id_o          <= fid[0];
            disp_field_id_o          <= fid[1];
        end
    end

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");

    property p_luma_fmt;
        @(posedge clk_i) disable iff (rst_i)
        cap1_q.addr_format && !cap1_q.data_mode[1] |=> cap1_luma_subpic_o;
    endproperty
    a_luma_fmt: assert property (p_luma_fmt)
        else $error("sub-picture select not driven");

    property p_luma_raw;
        @(posedge clk_i) disable iff (rst_i)
        cap1_q.data_mode[1] |=> !cap1_luma_subpic_o;
    endproperty
    a_luma_raw: assert property (p_luma_raw)
        else $error("address format applied in raw mode");

    property p_anc_raster;
        @(posedge clk_i) disable iff (rst_i)
        cap1_q.addr_format |=> !cap1_anc_subpic_o;
    endproperty
    a_anc_raster: assert property (p_anc_raster)
        else $error("ancillary data left raster order");

    property p_force_mux;
        @(posedge clk_i) disable iff (rst_i)
        cap1_mux0_wr |=> cap0_q.luma_chroma_mux ##1 cap0_ctrl_o[3];
    endproperty
    a_force_mux: assert property (p_force_mux)
        else $error("first channel mux bit not forced");

    property p_indep;
        @(posedge clk_i) disable iff (rst_i)
        !cap0_q.data_mode[1] && cap0_q.luma_chroma_mux
        && cap1_q.luma_chroma_mux && cap0_q.enable && !cap1_q.enable
        |=> status_o.cap0_active && !status_o.cap1_active;
    endproperty
    a_indep: assert property (p_indep)
        else $error("independent channel start failed");

    property p_raw_both;
        @(posedge clk_i) disable iff (rst_i)
        cap0_q.data_mode[1] && !(cap0_q.enable && cap1_q.enable)
        |=> !status_o.started;
    endproperty
    a_raw_both: assert property (p_raw_both)
        else $error("raw mode started without both enables");

    property p_disable;
        @(posedge clk_i) disable iff (rst_i)
        !cap1_q.enable |=> !status_o.cap1_active;
    endproperty
    a_disable: assert property (p_disable)
        else $error("disabled channel reported active");

    property p_ro_bits;
        @(posedge clk_i) disable iff (rst_i)
        (32'(disp_q) & ~DISP_WR_MASK) == 32'h0000_0000;
    endproperty
    a_ro_bits: assert property (p_ro_bits)
        else $error("read-only display bit written");

    property p_edge_out;
        @(posedge clk_i) disable iff (rst_i)
        $rose(disp_q.clock_edge_select) |=> disp_clock_edge_select_o;
    endproperty
    a_edge_out: assert property (p_edge_out)
        else $error("edge select not driven out");

endmodule : vpc_regs

// ### verification/video_port_channel_control_bench.sv
// Purpose: Self-checking bench for the video port control register bank
// Assumes: Classic Wishbone, ack one wait after request, reset held 6 edges
// Notes:   Expected values come from the register layout and field rules
`timescale 1ns/1ps
module video_port_channel_control_bench;
    import vpc_pkg::*;

    logic                  clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    logic                  cyc_i = 1'b0;
    logic                  stb_i = 1'b0;
    logic                  we_i  = 1'b0;
    logic [WB_AW-1:0]      adr_i = 8'h00;
    logic [3:0]            sel_i = 4'h0;
    logic [WB_DW-1:0]      dat_i = 32'h0000_0000;
    logic [WB_DW-1:0]      dat_o;
    logic                  ack_o;
    logic                  c1_pulse = 1'b0;
    logic                  c1_field = 1'b0;
    logic                  d_pulse  = 1'b0;
    logic                  d_field  = 1'b0;
    vpc_cap_ctrl_t         cap0_ctrl, cap1_ctrl;
    vpc_disp_ctrl_t        disp_ctrl;
    vpc_status_t           status;
    logic                  luma_sp, anc_sp, edge_sel, c1_fid, d_fid;
    logic [31:0]           rd;
    int                    err_count   = 0;
    int                    check_count = 0;

    vpc_regs u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o),
        .cap1_frame_pulse_i(c1_pulse), .cap1_field_i(c1_field),
        .disp_frame_pulse_i(d_pulse), .disp_field_i(d_field),
        .cap0_ctrl_o(cap0_ctrl), .cap1_ctrl_o(cap1_ctrl),
        .disp_ctrl_o(disp_ctrl), .status_o(status),
        .cap1_luma_subpic_o(luma_sp), .cap1_anc_subpic_o(anc_sp),
        .disp_clock_edge_select_o(edge_sel),
        .cap1_field_id_o(c1_fid), .disp_field_id_o(d_fid)
    );

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic check32(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : check32

    task automatic check1(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask : check1

    // One classic cycle; held until ack is sampled high
    // No cycle count assumed; only the watchdog ends a stuck wait
    task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w;
        adr_i <= a; sel_i <= s; dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(a, 1'b1, 4'hF, d);
    endtask : wr

    // Reads after outputs and status have settled
    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] m, input logic [31:0] e);
        repeat (3) @(posedge clk_i);
        wb(a, 1'b0, 4'hF, 32'h0000_0000);
        check32(nm, e, rd & m);
    endtask : rdchk

    task automatic pulse(input logic disp, input logic f);
        @(posedge clk_i);
        if (disp) begin d_field <= f; d_pulse <= 1'b1; end
        else begin c1_field <= f; c1_pulse <= 1'b1; end
        @(posedge clk_i);
        d_pulse <= 1'b0; c1_pulse <= 1'b0;
    endtask : pulse

    // Watchdog cuts a hang short
    initial begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        give_verdict();
    end

    // Test sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("cap0", ADDR_CAP0, 32'hFFFF_FFFF, 32'h0);
        rdchk("cap1", ADDR_CAP1, 32'hFFFF_FFFF, 32'h0);
        rdchk("disp", ADDR_DISP, 32'hFFFF_FFFF, 32'h0);
        $display("test reset done");

        wr(ADDR_DISP, 32'hFFFF_FFFF);
        rdchk("disp", ADDR_DISP, 32'hFFFF_FFFF, 32'h8000_7FDB);
        check1("edge_sel", 1'b1, edge_sel);
        check32("disp_ctrl", 32'h8000_7FDB, disp_ctrl);
        wr(ADDR_DISP, 32'h0);
        wb(ADDR_DISP, 1'b1, 4'h1, 32'hFFFF_FFFF);
        rdchk("disp", ADDR_DISP, 32'hFFFF_FFFF, 32'h0000_00DB);
        check1("edge_sel", 1'b0, edge_sel);
        $display("test display done");

        pulse(1'b1, 1'b1);
        rdchk("disp", ADDR_DISP, 32'hFFFF_FFFF, 32'h0000_00FB);
        check1("disp_fid", 1'b1, d_fid);
        d_field <= 1'b0;
        rdchk("disp", ADDR_DISP, 32'h20, 32'h20);
        pulse(1'b0, 1'b1);
        rdchk("cap1", ADDR_CAP1, 32'h20, 32'h20);
        check1("cap1_fid", 1'b1, c1_fid);
        $display("test field done");

        wr(8'h10, 32'hFFFF_FFFF);
        rdchk("unmapped", 8'h10, 32'hFFFF_FFFF, 32'h0);
        $display("test unmapped done");

        wr(ADDR_CAP1, 32'h19);
        rdchk("cap1", ADDR_CAP1, 32'h1F, 32'h19);
        check1("luma_sp", 1'b1, luma_sp);
        check1("anc_sp", 1'b0, anc_sp);
        check1("cap1_en", 1'b1, cap1_ctrl.enable);
        wr(ADDR_CAP1, 32'h1D);
        rdchk("cap1", ADDR_CAP1, 32'h1F, 32'h1D);
        check1("luma_sp", 1'b0, luma_sp);
        $display("test address format done");

        wr(ADDR_CAP1, 32'h09);
        wr(ADDR_CAP0, 32'h08);
        rdchk("status", ADDR_STAT, 32'h1F, 32'h05);
        // Clear first channel mux so the forcing below can be seen
        wr(ADDR_CAP0, 32'h00);
        rdchk("cap0", ADDR_CAP0, 32'h1F, 32'h00);
        wr(ADDR_CAP1, 32'h01);
        rdchk("cap0", ADDR_CAP0, 32'h1F, 32'h08);
        rdchk("status", ADDR_STAT, 32'h1F, 32'h00);
        wr(ADDR_CAP0, 32'h01);
        rdchk("cap0", ADDR_CAP0, 32'h1F, 32'h09);
        rdchk("status", ADDR_STAT, 32'h1F, 32'h07);
        check1("cap0_mux", 1'b1, cap0_ctrl.luma_chroma_mux);
        $display("test interlock done");

        wr(ADDR_CAP0, 32'h05);
        wr(ADDR_CAP1, 32'h05);
        rdchk("status", ADDR_STAT, 32'h1F, 32'h0F);
        wr(ADDR_CAP1, 32'h04);
        rdchk("status", ADDR_STAT, 32'h1F, 32'h08);
        // Unequal data modes raise the mismatch flag
        wr(ADDR_CAP1, 32'h02);
        rdchk("status", ADDR_STAT, 32'h1F, 32'h18);
        check32("status_o", 32'h0000_0018, status);
        $display("test raw mode done");
        give_verdict();
    end
endmodule : video_port_channel_control_bench
